// [design/lcdhi_consts.svh]
`ifndef LCDHI_CONSTS_SVH
`define LCDHI_CONSTS_SVH
// ==========================================
// memory geometry
`define LCDHI_RAM_DEPTH 2304
`define LCDHI_IND_PAGE 4'h8
`define LCDHI_COL_MAX 8'hff
`define LCDHI_SEG_LAST 8'hdf
`define LCDHI_LINE_LAST 7'h40
`define LCDHI_LINES 7'h41
`define LCDHI_BUSY_BIT 7
// ==========================================
// command codes and masks
`define LCDHI_CMD_PAGE 8'hb0
`define LCDHI_CMD_COL_HI 8'h10
`define LCDHI_CMD_COL_LO 8'h00
`define LCDHI_CMD_START 8'h40
`define LCDHI_CMD_ADC 8'ha0
`define LCDHI_CMD_REVERSE 8'ha6
`define LCDHI_CMD_ALL_ON 8'ha4
`define LCDHI_CMD_DISP_ON 8'hae
`define LCDHI_MASK_NIB 8'hf0
`define LCDHI_MASK_START 8'hc0
`define LCDHI_MASK_BIT0 8'hfe
// ==========================================
// refresh rate
`define LCDHI_REFRESH_DIV 4'h3
`endif

// [design/lcdhi_pkg.sv]
`default_nettype none
package lcdhi_pkg;
    typedef logic [3:0] lcdhi_page_t;
    typedef logic [7:0] lcdhi_col_t;
    typedef enum logic [1:0] {
        LCDHI_WR_NONE = 2'b00,
        LCDHI_WR_DATA = 2'b01,
        LCDHI_WR_CMD = 2'b10
    } lcdhi_wr_t;
    typedef enum logic {
        LCDHI_IDLE = 1'b0,
        LCDHI_COMMIT = 1'b1
    } lcdhi_acc_t;
endpackage
`default_nettype wire

// [design/lcdhi_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface lcdhi_if;
    import lcdhi_pkg::*;
    logic ser_vld;
    logic ser_dc;
    logic [7:0] ser_byte;
    logic h_we;
    lcdhi_page_t h_page;
    lcdhi_col_t h_col;
    logic [7:0] h_wdata;
    logic [7:0] h_rdata;
    lcdhi_page_t d_page;
    lcdhi_col_t d_col;
    logic [7:0] d_rdata;
    modport ser (output ser_vld, ser_dc, ser_byte);
    modport ram (input h_we, h_page, h_col, h_wdata, d_page, d_col, output h_rdata, d_rdata);
    modport core (input ser_vld, ser_dc, ser_byte, h_rdata, d_rdata,
                  output h_we, h_page, h_col, h_wdata, d_page, d_col);
endinterface
`default_nettype wire

// [design/lcdhi_serial.sv]
`timescale 1ns/1ps
`default_nettype none
module lcdhi_serial import lcdhi_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sampled pins
    input wire logic enable,
    input wire logic sclk_rise,
    input wire logic sdat,
    input wire logic dc_sel,
    // assembled bytes
    lcdhi_if.ser bus
);
    logic [7:0] sh_q;
    logic [2:0] cnt_q;

    // ==========================================
    // shift register and bit counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_q <= 8'h00;
            cnt_q <= 3'h0;
        end
        else if (!enable)
        begin
            sh_q <= 8'h00; // [RL7]
            cnt_q <= 3'h0; // [RL7]
        end
        else if (sclk_rise)
        begin
            sh_q <= {sh_q[6:0], sdat}; // [RL4] [RL5]
            cnt_q <= cnt_q + 3'h1; // [RL4]
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus.ser_vld <= 1'b0;
            bus.ser_dc <= 1'b0;
            bus.ser_byte <= 8'h00;
        end
        else
        begin
            bus.ser_vld <= enable && sclk_rise && cnt_q == 3'h7; // [RL5]
            if (enable && sclk_rise && cnt_q == 3'h7)
            begin
                bus.ser_byte <= {sh_q[6:0], sdat}; // [RL5]
                bus.ser_dc <= dc_sel; // [RL6]
            end
        end
    end

    a_ser_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !enable |=> cnt_q == 3'h0 && sh_q == 8'h00) // [RL7]
        else $error("serial state not cleared while deselected");
    a_ser_eighth: assert property (@(posedge clk) disable iff (!rst_n)
        bus.ser_vld |-> $past(cnt_q) == 3'h7 && $past(sclk_rise)) // [RL5]
        else $error("serial byte not on eighth edge");
endmodule
`default_nettype wire

// [design/lcdhi_ram.sv]
`timescale 1ns/1ps
`include "lcdhi_consts.svh"
`default_nettype none
module lcdhi_ram import lcdhi_pkg::*; (
    // clock
    input wire logic clk,
    // host and refresh ports
    lcdhi_if.ram bus
);
    // nine pages of 256 bytes; the indicator page keeps bit 0 only
    logic [7:0] mem_q [0:`LCDHI_RAM_DEPTH-1];

    // ==========================================
    // separate ports: refresh never waits on the host
    assign bus.h_rdata = mem_q[{bus.h_page, bus.h_col}]; // [RL13]

    always_ff @(posedge clk)
    begin
        if (bus.h_we)
        begin
            mem_q[{bus.h_page, bus.h_col}] <= bus.h_wdata; // [RL13]
        end
    end

    always_ff @(posedge clk)
    begin
        bus.d_rdata <= mem_q[{bus.d_page, bus.d_col}]; // [RL21]
    end
endmodule
`default_nettype wire

// [design/lcdhi_top.sv]
`timescale 1ns/1ps
`include "lcdhi_consts.svh"
`default_nettype none
// Summary of operation
// [RL1] strap picks parallel byte port or serial
// [RL2] bus family strap picks 68 or 80 strobes
// [RL3] select line and direction decode access kind
// [RL4] serial uses 8-bit shifter, 3-bit counter
// [RL5] serial msb first, byte at eighth edge
// [RL6] select line sampled at each eighth edge
// [RL7] deselect clears shifter and counter
// [RL8] serial port has no read path
// [RL9] port works only with both selects active
// [RL10] data writes go through holder, no waits
// [RL11] first data read after address is dummy
// [RL12] status read shows busy on bit 7
// [RL13] ram is 65 by 256 bits, paged
// [RL14] page 8 stores only data bit 0
// [RL15] column steps by one per data access
// [RL16] column stops at its top value
// [RL17] page never advances by itself
// [RL18] direction bit mirrors column to segment map
// [RL19] readout shows 65 lines from start line
// [RL20] display controls touch output latch only
// [RL21] host access independent of refresh readout
// [RL22] 80-style write taken at strobe rise
// [RL23] 80-style bus driven only during read strobe
// [RL24] undefined status bits read zero
module lcdhi_top import lcdhi_pkg::*; (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // static straps
    input wire logic PAR_SERIAL_SELECT,
    input wire logic BUS_FAMILY_SELECT,
    // host control pins
    input wire logic CHIP_SELECT_LOW_ACTIVE_N,
    input wire logic CHIP_SELECT_HIGH_ACTIVE,
    input wire logic DATA_COMMAND_SELECT,
    input wire logic READ_STROBE_N_E,
    input wire logic WRITE_STROBE_N_RW,
    // data bus
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    // display readout
    output logic PIXEL_STB,
    output logic PIXEL_ON,
    output logic [7:0] SEG_NUM,
    output logic [6:0] COM_NUM
);
    lcdhi_if u_if ();

    logic [14:0] pin_raw;
    logic [14:0] meta_q;
    logic [14:0] sync_q;
    logic [2:0] prev_q;
    logic par_s, c86_s, rd_s, wr_s, cs_n_s, cs2_s, a0_s;
    logic [7:0] d_s;
    logic cs_act, par_en, e_fall, wr_rise, sclk_rise;
    logic par_wr, rd_end, rd_act, rd_data_ev, busy;
    logic wr_ev, wr_dc;
    logic [7:0] wr_byte;
    lcdhi_wr_t wr_kind;
    lcdhi_acc_t acc_q;
    logic [7:0] holder_q;
    lcdhi_page_t page_q;
    lcdhi_col_t col_q;
    logic [5:0] start_q;
    logic adc_q, reverse_q, all_on_q, disp_on_q;
    logic [3:0] div_q;
    logic tick;
    logic [7:0] seg_q;
    logic [6:0] com_q;
    logic [6:0] line_sum, line;
    logic p1_vld_q;
    logic [2:0] p1_bit_q;
    logic [7:0] p1_seg_q;
    logic [6:0] p1_com_q;

    // ==========================================
    // pin synchronisers
    assign pin_raw = {PAR_SERIAL_SELECT, BUS_FAMILY_SELECT, READ_STROBE_N_E, WRITE_STROBE_N_RW,
                      CHIP_SELECT_LOW_ACTIVE_N, CHIP_SELECT_HIGH_ACTIVE, DATA_COMMAND_SELECT, DATA_IN};

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            meta_q <= 15'h0000;
            sync_q <= 15'h0000;
            prev_q <= 3'h0;
        end
        else
        begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
            prev_q <= {sync_q[12], sync_q[11], sync_q[6]};
        end
    end

    assign par_s = sync_q[14];
    assign c86_s = sync_q[13];
    assign rd_s = sync_q[12];
    assign wr_s = sync_q[11];
    assign cs_n_s = sync_q[10];
    assign cs2_s = sync_q[9];
    assign a0_s = sync_q[8];
    assign d_s = sync_q[7:0];

    // ==========================================
    // strobe decode
    assign cs_act = !cs_n_s && cs2_s; // [RL9]
    assign par_en = par_s && cs_act; // [RL1] [RL9]
    assign e_fall = prev_q[2] && !rd_s;
    assign wr_rise = !prev_q[1] && wr_s; // [RL22]
    assign sclk_rise = sync_q[6] && !prev_q[0];
    // 68 style: direction is held across the enable pulse, so take it from before the fall
    assign par_wr = par_en && (c86_s ? (e_fall && !prev_q[1]) : wr_rise); // [RL2] [RL3]
    assign rd_end = par_en && (c86_s ? (e_fall && prev_q[1]) : (rd_s && !prev_q[2])); // [RL2] [RL3]
    assign rd_act = par_en && (c86_s ? (rd_s && wr_s) : !rd_s); // [RL23]
    assign busy = acc_q == LCDHI_COMMIT;
    assign rd_data_ev = rd_end && a0_s && !busy; // [RL3]

    assign wr_ev = par_wr || u_if.ser_vld;
    assign wr_dc = par_wr ? a0_s : u_if.ser_dc; // [RL3] [RL6]
    assign wr_byte = par_wr ? d_s : u_if.ser_byte;

    always_comb
    begin
        wr_kind = LCDHI_WR_NONE;
        if (wr_ev && !busy) // [RL12]
        begin
            wr_kind = wr_dc ? LCDHI_WR_DATA : LCDHI_WR_CMD; // [RL3]
        end
    end

    lcdhi_serial u_serial (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .enable(cs_act && !par_s), // [RL1] [RL7]
        .sclk_rise(sclk_rise),
        .sdat(d_s[7]),
        .dc_sel(a0_s),
        .bus(u_if.ser)
    );

    // ==========================================
    // write pipeline through the holder
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            acc_q <= LCDHI_IDLE;
        end
        else
        begin
            unique case (acc_q)
                LCDHI_IDLE:
                begin
                    if (wr_kind == LCDHI_WR_DATA)
                    begin
                        acc_q <= LCDHI_COMMIT; // [RL10]
                    end
                end
                LCDHI_COMMIT:
                begin
                    acc_q <= LCDHI_IDLE;
                end
            endcase
        end
    end

    // holder also buffers reads, hence the stale first read after any address change
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            holder_q <= 8'h00;
        end
        else if (wr_kind == LCDHI_WR_DATA)
        begin
            holder_q <= wr_byte; // [RL10]
        end
        else if (rd_data_ev)
        begin
            holder_q <= u_if.h_rdata; // [RL11]
        end
    end

    assign u_if.h_we = busy; // [RL10]
    assign u_if.h_page = page_q;
    assign u_if.h_col = col_q;
    assign u_if.h_wdata = (page_q == `LCDHI_IND_PAGE) ? {7'h00, holder_q[0]} : holder_q; // [RL14]

    // ==========================================
    // page and column addressing
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            page_q <= 4'h0;
            col_q <= 8'h00;
        end
        else if (wr_kind == LCDHI_WR_CMD)
        begin
            if ((wr_byte & `LCDHI_MASK_NIB) == `LCDHI_CMD_PAGE && wr_byte[3:0] <= `LCDHI_IND_PAGE)
            begin
                page_q <= wr_byte[3:0]; // [RL17]
            end
            if ((wr_byte & `LCDHI_MASK_NIB) == `LCDHI_CMD_COL_HI)
            begin
                col_q[7:4] <= wr_byte[3:0];
            end
            if ((wr_byte & `LCDHI_MASK_NIB) == `LCDHI_CMD_COL_LO)
            begin
                col_q[3:0] <= wr_byte[3:0];
            end
        end
        else if (busy || rd_data_ev)
        begin
            col_q <= (col_q == `LCDHI_COL_MAX) ? col_q : col_q + 8'h01; // [RL15] [RL16] [RL17]
        end
    end

    // ==========================================
    // display control settings
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            start_q <= 6'h00;
            adc_q <= 1'b0;
            reverse_q <= 1'b0;
            all_on_q <= 1'b0;
            disp_on_q <= 1'b0;
        end
        else if (wr_kind == LCDHI_WR_CMD)
        begin
            if ((wr_byte & `LCDHI_MASK_START) == `LCDHI_CMD_START)
            begin
                start_q <= wr_byte[5:0]; // [RL19]
            end
            if ((wr_byte & `LCDHI_MASK_BIT0) == `LCDHI_CMD_ADC)
            begin
                adc_q <= wr_byte[0]; // [RL18]
            end
            if ((wr_byte & `LCDHI_MASK_BIT0) == `LCDHI_CMD_REVERSE)
            begin
                reverse_q <= wr_byte[0]; // [RL20]
            end
            if ((wr_byte & `LCDHI_MASK_BIT0) == `LCDHI_CMD_ALL_ON)
            begin
                all_on_q <= wr_byte[0]; // [RL20]
            end
            if ((wr_byte & `LCDHI_MASK_BIT0) == `LCDHI_CMD_DISP_ON)
            begin
                disp_on_q <= wr_byte[0]; // [RL20]
            end
        end
    end

    // ==========================================
    // host data bus
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            DATA_OE <= 1'b0;
            DATA_OUT <= 8'h00;
        end
        else
        begin
            DATA_OE <= rd_act; // [RL8] [RL9] [RL23]
            DATA_OUT <= a0_s ? holder_q : {busy, 7'h00}; // [RL11] [RL12] [RL24]
        end
    end

    // ==========================================
    // refresh scanner
    assign tick = div_q == `LCDHI_REFRESH_DIV;
    assign line_sum = {1'b0, start_q} + com_q;
    assign line = (line_sum >= `LCDHI_LINES) ? line_sum - `LCDHI_LINES : line_sum; // [RL19]
    assign u_if.d_page = line[6:3];
    assign u_if.d_col = adc_q ? `LCDHI_COL_MAX - seg_q : seg_q; // [RL18]

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            div_q <= 4'h0;
            seg_q <= 8'h00;
            com_q <= 7'h00;
        end
        else
        begin
            div_q <= tick ? 4'h0 : div_q + 4'h1;
            if (tick)
            begin
                seg_q <= (seg_q == `LCDHI_SEG_LAST) ? 8'h00 : seg_q + 8'h01;
                if (seg_q == `LCDHI_SEG_LAST)
                begin
                    com_q <= (com_q == `LCDHI_LINE_LAST) ? 7'h00 : com_q + 7'h01; // [RL19]
                end
            end
        end
    end

    // ram read lands with the first stage; reverse, all-on and display-on are applied only at the latch
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            p1_vld_q <= 1'b0;
            p1_bit_q <= 3'h0;
            p1_seg_q <= 8'h00;
            p1_com_q <= 7'h00;
            PIXEL_STB <= 1'b0;
            PIXEL_ON <= 1'b0;
            SEG_NUM <= 8'h00;
            COM_NUM <= 7'h00;
        end
        else
        begin
            p1_vld_q <= tick;
            p1_bit_q <= line[2:0];
            p1_seg_q <= seg_q;
            p1_com_q <= com_q;
            PIXEL_STB <= p1_vld_q;
            PIXEL_ON <= disp_on_q && (all_on_q || (u_if.d_rdata[p1_bit_q] ^ reverse_q)); // [RL20] [RL21]
            SEG_NUM <= p1_seg_q;
            COM_NUM <= p1_com_q;
        end
    end

    lcdhi_ram u_ram (
        .clk(CORE_CLK),
        .bus(u_if.ram)
    );

    // ==========================================
    // checks
    a_col_saturate: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RL16]
        (busy || rd_data_ev) && col_q == `LCDHI_COL_MAX |=> col_q == `LCDHI_COL_MAX)
        else $error("column wrapped past top");
    a_col_step: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RL15]
        (busy || rd_data_ev) && col_q != `LCDHI_COL_MAX |=> col_q == $past(col_q) + 8'h01)
        else $error("column did not step by one");
    a_serial_no_drive: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RL8]
        !par_s |=> !DATA_OE)
        else $error("bus driven in serial mode");
    a_deselect_float: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RL9]
        !cs_act |=> !DATA_OE)
        else $error("bus driven while deselected");
    a_status_word: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RL12]
        rd_act && !a0_s |=> DATA_OUT[6:0] == 7'h00 && DATA_OUT[`LCDHI_BUSY_BIT] == $past(busy))
        else $error("status word wrong");
    a_commit_once: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RL10]
        wr_kind == LCDHI_WR_DATA |=> u_if.h_we ##1 !u_if.h_we)
        else $error("holder not committed in one cycle");
    a_ind_page_bit: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RL14]
        u_if.h_we && page_q == `LCDHI_IND_PAGE |-> u_if.h_wdata[7:1] == 7'h00)
        else $error("indicator page stores upper bits");
    a_dummy_read: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RL11]
        rd_data_ev |=> holder_q === $past(u_if.h_rdata))
        else $error("holder not loaded on data read");
    a_pixel_blank: assert property (@(posedge CORE_CLK) disable iff (!NRST) // [RL20]
        !disp_on_q |=> !PIXEL_ON)
        else $error("pixel on while display off");
endmodule
`default_nettype wire

// [dv/lcdhi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lcdhi_host_model (
    // clock and strap
    input wire logic clk,
    input wire logic fam,
    // host pins
    output logic cs_n,
    output logic cs_hi,
    output logic dc,
    output logic rd_e,
    output logic wr_rw,
    output logic [7:0] drv,
    output logic drv_en,
    // device answer
    input wire logic [7:0] din,
    input wire logic oe,
    // captured read
    output logic rd_vld,
    output logic [8:0] rd_val
);
    logic act = 1'b0;
    logic isrd = 1'b1;
    // ==========================================
    // strobe styles
    assign rd_e = fam ? act : !(act && isrd);
    assign wr_rw = fam ? isrd : !(act && !isrd);
    initial
    begin
        cs_n = 1'b1;
        cs_hi = 1'b0;
        dc = 1'b0;
        drv = 8'h00;
        drv_en = 1'b1;
        rd_vld = 1'b0;
        rd_val = 9'h000;
    end
    // ==========================================
    // one parallel access, strobe held 6 cycles
    task automatic acc(input logic sel, input logic rd, input logic a0, input logic [7:0] d);
        @(negedge clk);
        cs_n = !sel;
        cs_hi = 1'b1;
        dc = a0;
        isrd = rd;
        drv = d;
        drv_en = !rd;
        @(negedge clk);
        act = 1'b1;
        repeat (5) @(negedge clk);
        if (rd)
        begin
            @(posedge clk);
            rd_val = oe ? {1'b1, din} : 9'h000;
        end
        @(negedge clk);
        act = 1'b0;
        // data outlives the strobe so the synced copy sees it at the write edge, WR rise or E fall
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        cs_hi = 1'b0;
        drv_en = 1'b0;
        isrd = 1'b1;
        if (rd)
        begin
            rd_vld = 1'b1;
            @(negedge clk);
            rd_vld = 1'b0;
        end
    endtask
    // ==========================================
    // serial frame, clock idles low between frames
    task automatic ser(input logic a0, input logic [7:0] b, input int n);
        @(negedge clk);
        cs_n = 1'b0;
        cs_hi = 1'b1;
        dc = a0;
        drv_en = 1'b1;
        drv = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            drv[7] = b[7 - i];
            repeat (4) @(negedge clk);
            drv[6] = 1'b1;
            repeat (4) @(negedge clk);
            drv[6] = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        cs_hi = 1'b0;
    endtask
endmodule
`default_nettype wire

// [dv/lcdhi_top_tb.sv]
`timescale 1ns/1ps
`include "lcdhi_consts.svh"
`default_nettype none
module lcdhi_top_tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic par_sel = 1'b1;
    logic fam = 1'b0;
    logic cs_n, cs_hi, dc, rd_e, wr_rw, h_en, rd_vld, data_oe;
    logic [7:0] h_drv, data_in, data_out;
    logic [7:0] v[8];
    logic [8:0] rd_val;
    logic [8:0] exp_q[$];
    logic pix_stb, pix_on;
    logic [7:0] seg_num;
    logic [6:0] com_num;
    logic px_q[$];
    int n_fail = 0;
    int checks_done = 0;
    initial forever #12.5 core_clk = ~core_clk;
    // released host lines show the inverse of their last value
    assign data_in = h_en ? h_drv : (data_oe ? data_out : ~h_drv);
    lcdhi_top u_lcdhi_top (
        .CORE_CLK(core_clk), .NRST(nrst), .PAR_SERIAL_SELECT(par_sel), .BUS_FAMILY_SELECT(fam),
        .CHIP_SELECT_LOW_ACTIVE_N(cs_n), .CHIP_SELECT_HIGH_ACTIVE(cs_hi), .DATA_COMMAND_SELECT(dc),
        .READ_STROBE_N_E(rd_e), .WRITE_STROBE_N_RW(wr_rw), .DATA_IN(data_in), .DATA_OUT(data_out),
        .DATA_OE(data_oe), .PIXEL_STB(pix_stb), .PIXEL_ON(pix_on), .SEG_NUM(seg_num), .COM_NUM(com_num));
    lcdhi_host_model u_lcdhi_host_model (
        .clk(core_clk), .fam(fam), .cs_n(cs_n), .cs_hi(cs_hi), .dc(dc), .rd_e(rd_e), .wr_rw(wr_rw),
        .drv(h_drv), .drv_en(h_en), .din(data_out), .oe(data_oe), .rd_vld(rd_vld), .rd_val(rd_val));
    // ==========================================
    // bus helpers
    task automatic cmd(input logic [7:0] c);
        u_lcdhi_host_model.acc(1'b1, 1'b0, 1'b0, c);
    endtask
    task automatic wr(input logic [7:0] d);
        u_lcdhi_host_model.acc(1'b1, 1'b0, 1'b1, d);
    endtask
    task automatic rd(input logic [8:0] e);
        exp_q.push_back(e);
        u_lcdhi_host_model.acc(1'b1, 1'b1, 1'b1, 8'h00);
    endtask
    task automatic addr(input logic [3:0] p, input logic [7:0] c);
        cmd(`LCDHI_CMD_PAGE | {4'h0, p});
        cmd(`LCDHI_CMD_COL_HI | {4'h0, c[7:4]});
        cmd(`LCDHI_CMD_COL_LO | {4'h0, c[3:0]});
    endtask
    // address set, then the dummy read that returns the holder
    task automatic seek(input logic [3:0] p, input logic [7:0] c, input logic [7:0] hold);
        addr(p, c);
        rd({1'b1, hold});
    endtask
    // settings command, then the pixel at segment 10 must match
    task automatic pix(input logic [7:0] c, input logic e);
        cmd(c);
        // let the new setting reach the ram read stage first
        repeat (4) @(negedge core_clk);
        px_q.push_back(e);
        while (px_q.size() != 0)
            @(negedge core_clk);
    endtask
    task automatic finish_test;
        if (exp_q.size() != 0 || px_q.size() != 0)
            n_fail++;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================
    // result monitor
    always @(posedge core_clk)
    begin
        if (rd_vld)
        begin
            checks_done++;
            if (exp_q.size() == 0)
            begin
                n_fail++;
                $display("[ERR] read_result expected none seen %h", rd_val);
            end
            else
            begin
                if (exp_q[0] !== rd_val)
                begin
                    n_fail++;
                    $display("[ERR] read_result expected %h seen %h", exp_q[0], rd_val);
                end
                void'(exp_q.pop_front());
            end
        end
    end
    // ==========================================
    // pixel monitor
    // sampled mid-cycle, away from the edge that launches the pixel
    always @(negedge core_clk)
    begin
        if (pix_stb && (seg_num > `LCDHI_SEG_LAST || com_num > `LCDHI_LINE_LAST))
        begin
            n_fail++;
            $display("[ERR] pixel_position expected in range seen %h %h", seg_num, com_num);
        end
        if (pix_stb && seg_num == 8'h10 && px_q.size() != 0)
        begin
            checks_done++;
            if (px_q[0] !== pix_on)
            begin
                n_fail++;
                $display("[ERR] pixel_on expected %b seen %b", px_q[0], pix_on);
            end
            void'(px_q.pop_front());
        end
    end
    initial
    begin
        #400us;
        n_fail++;
        finish_test();
    end
    // ==========================================
    // main sequence
    initial
    begin
        void'($urandom(81272));
        foreach (v[i])
            v[i] = 8'($urandom());
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        addr(4'h0, 8'h00);
        wr(v[0]);
        wr(v[1]);
        seek(4'h0, 8'h00, v[1]);
        rd({1'b1, v[0]});
        rd({1'b1, v[1]});
        exp_q.push_back(9'h100);
        u_lcdhi_host_model.acc(1'b1, 1'b1, 1'b0, 8'h00);
        addr(4'h0, 8'hff);
        wr(v[2]);
        wr(v[3]);
        seek(4'h0, 8'hff, v[3]);
        rd({1'b1, v[3]});
        rd({1'b1, v[3]});
        addr(4'h8, 8'h05);
        wr(8'hff);
        seek(4'h8, 8'h05, 8'hff);
        rd(9'h101);
        @(negedge core_clk);
        fam = 1'b1;
        addr(4'h1, 8'h00);
        wr(v[4]);
        seek(4'h0, 8'h00, v[4]);
        rd({1'b1, v[0]});
        seek(4'h1, 8'h00, v[1]);
        rd({1'b1, v[4]});
        @(negedge core_clk);
        fam = 1'b0;
        addr(4'h2, 8'h00);
        wr(v[5]);
        u_lcdhi_host_model.acc(1'b0, 1'b0, 1'b1, v[6]);
        exp_q.push_back(9'h000);
        u_lcdhi_host_model.acc(1'b0, 1'b1, 1'b1, 8'h00);
        seek(4'h2, 8'h00, v[5]);
        rd({1'b1, v[5]});
        @(negedge core_clk);
        par_sel = 1'b0;
        repeat (4) @(negedge core_clk);
        u_lcdhi_host_model.ser(1'b0, `LCDHI_CMD_PAGE | 8'h03, 8);
        u_lcdhi_host_model.ser(1'b0, `LCDHI_CMD_COL_HI, 8);
        u_lcdhi_host_model.ser(1'b0, `LCDHI_CMD_COL_LO, 8);
        u_lcdhi_host_model.ser(1'b1, v[7], 3);
        u_lcdhi_host_model.ser(1'b1, v[7], 8);
        exp_q.push_back(9'h000);
        u_lcdhi_host_model.acc(1'b1, 1'b1, 1'b1, 8'h00);
        @(negedge core_clk);
        par_sel = 1'b1;
        repeat (4) @(negedge core_clk);
        seek(4'h3, 8'h00, v[7]);
        rd({1'b1, v[7]});
        // column 10 all ones and column ef all zeros on every page, whatever line is scanned
        for (int p = 0; p < 9; p++)
        begin
            addr(4'(p), 8'h10);
            wr(8'hff);
            addr(4'(p), 8'hef);
            wr(8'h00);
        end
        pix(`LCDHI_CMD_DISP_ON | 8'h01, 1'b1);
        pix(`LCDHI_CMD_ADC | 8'h01, 1'b0);
        pix(`LCDHI_CMD_ALL_ON | 8'h01, 1'b1);
        cmd(`LCDHI_CMD_ALL_ON);
        pix(`LCDHI_CMD_REVERSE | 8'h01, 1'b1);
        pix(`LCDHI_CMD_DISP_ON, 1'b0);
        // display controls must have left the ram alone
        seek(4'h0, 8'h10, 8'h00);
        rd(9'h1ff);
        repeat (10) @(negedge core_clk);
        finish_test();
    end
endmodule
`default_nettype wire
